// ===== dmaes_pkg.sv
/*
  Package for the DMA event selector: register addresses, field layout,
  reset values, selector codes and the bus state encoding.
  Assumes a 32-bit Avalon-MM bus carrying full byte addresses.
*/
package dmaes_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int unsigned NUM_CHANNELS   = 16;
  localparam int unsigned CODE_W         = 6;
  localparam int unsigned NUM_EVENTS     = 64;
  localparam int unsigned FIELD_STRIDE   = 8;
  localparam int unsigned FIELDS_PER_REG = 4;
  localparam int unsigned CHAIN_FIRST    = 8;
  localparam int unsigned CHAIN_LAST     = 11;
  localparam int unsigned NUM_CHAIN      = 4;

  // ---------------------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [31:0] ADDR_ROUTE_SEL_CH0_3   = 32'h01A0FF00;
  localparam logic [31:0] ADDR_ROUTE_SEL_CH4_7   = 32'h01A0FF04;
  localparam logic [31:0] ADDR_ROUTE_SEL_CH12_15 = 32'h01A0FF0C;
  localparam logic [31:0] ADDR_GPIO_COMBINE      = 32'h01A0FF10;
  localparam logic [31:0] ADDR_TRIGGER_STATUS    = 32'h01A0FF14;

  // ---------------------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------------------
  localparam logic [31:0] ROUTE_SEL_WRITE_MASK   = 32'h3F3F3F3F;
  localparam logic [3:0]  GPIO_COMBINE_RESET     = 4'h0;
  localparam int unsigned GPIO_SHARED_FIRST      = 4;
  localparam int unsigned GPIO_SHARED_COUNT      = 4;

  // ---------------------------------------------------------------------------
  // Selector codes (first code of each group)
  // ---------------------------------------------------------------------------
  localparam logic [5:0] CODE_HOST_PORT      = 6'h00;
  localparam logic [5:0] CODE_TIMER0         = 6'h01;
  localparam logic [5:0] CODE_TIMER1         = 6'h02;
  localparam logic [5:0] CODE_MEM_REFRESH    = 6'h03;
  localparam logic [5:0] CODE_GPIO_PIN4      = 6'h04;
  localparam logic [5:0] CODE_GPIO_COMBINED  = 6'h08;
  localparam logic [5:0] CODE_SERIAL0_TX     = 6'h0C;
  localparam logic [5:0] CODE_SERIAL0_RX     = 6'h0D;
  localparam logic [5:0] CODE_SERIAL1_TX     = 6'h0E;
  localparam logic [5:0] CODE_SERIAL1_RX     = 6'h0F;
  localparam logic [5:0] CODE_AUDIO0_FIRST   = 6'h20;
  localparam logic [5:0] CODE_AUDIO1_FIRST   = 6'h26;
  localparam logic [5:0] CODE_TWOWIRE0_RX    = 6'h2C;
  localparam logic [5:0] CODE_TWOWIRE0_TX    = 6'h2D;
  localparam logic [5:0] CODE_TWOWIRE1_RX    = 6'h2E;
  localparam logic [5:0] CODE_TWOWIRE1_TX    = 6'h2F;
  localparam logic [5:0] CODE_GPIO_PIN8      = 6'h30;
  localparam int unsigned AUDIO_EVENTS       = 6;

  // ---------------------------------------------------------------------------
  // Avalon responses and bus states
  // ---------------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_SLAVEERROR  = 2'h2;

  typedef enum logic [1:0] {
    DMAES_BUS_IDLE = 2'h1,
    DMAES_BUS_ACK  = 2'h2
  } dmaes_bus_state_type;

endpackage : dmaes_pkg

// ===== dmaes_chan_mux.sv
/*
  One channel's event picker: returns the event bit that the channel's
  selector code points at.
  Assumes the event vector already holds zero at every reserved code.
*/
`timescale 1ns/1ps

module dmaes_chan_mux
  import dmaes_pkg::*;
(
  input  wire logic [CODE_W-1:0]     code_i,
  input  wire logic [NUM_EVENTS-1:0] events_i,
  output logic                       hit_o
);

  always_comb begin
    hit_o = events_i[code_i];
  end

endmodule : dmaes_chan_mux

// ===== dmaes_selector.sv
/*
  DMA event selector: routes peripheral synchronisation events onto the
  trigger inputs of a sixteen-channel DMA controller, with the selector
  registers on an Avalon-MM slave with waitrequest.
  Assumes all event inputs are single-cycle pulses from logic on core_clk_i.
*/
// Functional notes
// - A trigger output exists for each of the sixteen DMA channels 0 to 15.
// - Channels 8 to 11 have no selector and follow only the chain completion codes.
// - Three selector registers at FF00, FF04 and FF0C serve channels 0-3, 4-7 and 12-15.
// - Each register holds four 6-bit fields at 5:0, 13:8, 21:16 and 29:24 in channel order.
// - After reset each routable channel's field holds its own channel number.
// - Codes 0 to 3 select host port, timer 0, timer 1 and memory refresh events.
// - Codes 4 to 7 select GPIO events 4 to 7, code 8 the combined GPIO event and codes 9 to 11 GPIO events 1 to 3.
// - Codes 12 to 15 select serial port 0 transmit and receive, then port 1.
// - Codes 32 to 43 select the six audio port events of port 0, then of port 1.
// - Codes 44 to 47 select two-wire receive and transmit of controller 0, then 1.
// - Codes 48 to 55 select GPIO events 8 to 15 in ascending order.
// - GPIO pins 0-3 and 8-15 feed the combined event; pins 4-7 feed it or their own.
// - A source takes effect only once its code is selected; its module controls it.
// - Reserved selector bits read as zero and ignore writes.
`timescale 1ns/1ps

module dmaes_selector
  import dmaes_pkg::*;
(
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_i,
  input  wire logic [31:0]             avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [31:0]             avs_writedata_i,
  input  wire logic [3:0]              avs_byteenable_i,
  output logic      [31:0]             avs_readdata_o,
  output logic                         avs_waitrequest_o,
  output logic      [1:0]              avs_response_o,
  input  wire logic                    host_port_event_i,
  input  wire logic                    timer0_event_i,
  input  wire logic                    timer1_event_i,
  input  wire logic                    memory_refresh_event_i,
  input  wire logic [15:0]             gpio_pin_event_i,
  input  wire logic                    serial0_tx_event_i,
  input  wire logic                    serial0_rx_event_i,
  input  wire logic                    serial1_tx_event_i,
  input  wire logic                    serial1_rx_event_i,
  input  wire logic [AUDIO_EVENTS-1:0] audio0_event_i,
  input  wire logic [AUDIO_EVENTS-1:0] audio1_event_i,
  input  wire logic                    twowire0_rx_event_i,
  input  wire logic                    twowire0_tx_event_i,
  input  wire logic                    twowire1_rx_event_i,
  input  wire logic                    twowire1_tx_event_i,
  input  wire logic [NUM_CHAIN-1:0]    chain_completion_code_i,
  output logic      [NUM_CHANNELS-1:0] channel_trigger_o
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  dmaes_bus_state_type bus_state_reg;
  dmaes_bus_state_type bus_state_next;
  logic [31:0]             readdata_reg;
  logic [31:0]             readdata_next;
  logic [1:0]              response_reg;
  logic [1:0]              response_next;
  logic [CODE_W-1:0]       channel_event_code_reg  [NUM_CHANNELS];
  logic [CODE_W-1:0]       channel_event_code_next [NUM_CHANNELS];
  logic [GPIO_SHARED_COUNT-1:0] gpio_combine_reg;
  logic [GPIO_SHARED_COUNT-1:0] gpio_combine_next;
  logic [NUM_CHANNELS-1:0] trigger_reg;
  logic [NUM_CHANNELS-1:0] trigger_next;
  wire  [NUM_CHANNELS-1:0] channel_hit;
  logic [NUM_EVENTS-1:0]   event_vector;
  logic [31:0]             write_mask;
  logic                    request;
  logic                    hit_sel0;
  logic                    hit_sel1;
  logic                    hit_sel3;
  logic                    hit_combine;
  logic                    hit_status;
  logic                    addr_mapped;
  logic                    gpio_combined_event;

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  always_comb begin
    request     = avs_read_i | avs_write_i;
    hit_sel0    = (avs_address_i == ADDR_ROUTE_SEL_CH0_3);
    hit_sel1    = (avs_address_i == ADDR_ROUTE_SEL_CH4_7);
    hit_sel3    = (avs_address_i == ADDR_ROUTE_SEL_CH12_15);
    hit_combine = (avs_address_i == ADDR_GPIO_COMBINE);
    hit_status  = (avs_address_i == ADDR_TRIGGER_STATUS);
    addr_mapped = hit_sel0 | hit_sel1 | hit_sel3 | hit_combine | hit_status;
    write_mask  = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                   {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}}
                  & ROUTE_SEL_WRITE_MASK;
  end

  // ---------------------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------------------
  // A request is seen in IDLE, read data is prepared there, and the access
  // completes in ACK, so every access is answered with one wait cycle.
  always_comb begin
    bus_state_next = bus_state_reg;
    readdata_next  = readdata_reg;
    response_next  = response_reg;
    case (bus_state_reg)
      DMAES_BUS_IDLE: begin
        if (request) begin
          bus_state_next = DMAES_BUS_ACK;
          response_next  = addr_mapped ? RESP_OKAY : RESP_SLAVEERROR;
          readdata_next  = 32'h00000000;
          if (avs_read_i) begin
            for (int f = 0; f < FIELDS_PER_REG; f++) begin
              if (hit_sel0) begin
                readdata_next[f*FIELD_STRIDE +: CODE_W] = channel_event_code_reg[f];
              end
              if (hit_sel1) begin
                readdata_next[f*FIELD_STRIDE +: CODE_W] = channel_event_code_reg[f+4];
              end
              if (hit_sel3) begin
                readdata_next[f*FIELD_STRIDE +: CODE_W] = channel_event_code_reg[f+12];
              end
            end
            if (hit_combine) begin
              readdata_next[GPIO_SHARED_COUNT-1:0] = gpio_combine_reg;
            end
            if (hit_status) begin
              readdata_next[NUM_CHANNELS-1:0] = trigger_reg;
            end
          end
        end
      end
      DMAES_BUS_ACK: begin
        bus_state_next = DMAES_BUS_IDLE;
      end
      default: begin
        bus_state_next = DMAES_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_state_reg <= DMAES_BUS_IDLE;
      readdata_reg  <= 32'h00000000;
      response_reg  <= RESP_OKAY;
    end else begin
      bus_state_reg <= bus_state_next;
      readdata_reg  <= readdata_next;
      response_reg  <= response_next;
    end
  end

  always_comb begin
    avs_waitrequest_o = (bus_state_reg != DMAES_BUS_ACK);
    avs_readdata_o    = readdata_reg;
    avs_response_o    = response_reg;
  end

  // ---------------------------------------------------------------------------
  // Selector and GPIO combine registers
  // ---------------------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      channel_event_code_next[c] = channel_event_code_reg[c];
    end
    gpio_combine_next = gpio_combine_reg;
    if ((bus_state_reg == DMAES_BUS_ACK) && avs_write_i) begin
      for (int f = 0; f < FIELDS_PER_REG; f++) begin
        if (hit_sel0) begin
          channel_event_code_next[f] =
            (channel_event_code_reg[f] & ~write_mask[f*FIELD_STRIDE +: CODE_W]) |
            (avs_writedata_i[f*FIELD_STRIDE +: CODE_W] & write_mask[f*FIELD_STRIDE +: CODE_W]);
        end
        if (hit_sel1) begin
          channel_event_code_next[f+4] =
            (channel_event_code_reg[f+4] & ~write_mask[f*FIELD_STRIDE +: CODE_W]) |
            (avs_writedata_i[f*FIELD_STRIDE +: CODE_W] & write_mask[f*FIELD_STRIDE +: CODE_W]);
        end
        if (hit_sel3) begin
          channel_event_code_next[f+12] =
            (channel_event_code_reg[f+12] & ~write_mask[f*FIELD_STRIDE +: CODE_W]) |
            (avs_writedata_i[f*FIELD_STRIDE +: CODE_W] & write_mask[f*FIELD_STRIDE +: CODE_W]);
        end
      end
      if (hit_combine && avs_byteenable_i[0]) begin
        gpio_combine_next = avs_writedata_i[GPIO_SHARED_COUNT-1:0];
      end
    end
  end

  // Channels 8 to 11 keep a constant code: they have no register behind them.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int c = 0; c < NUM_CHANNELS; c++) begin
        channel_event_code_reg[c] <= CODE_W'(c);
      end
      gpio_combine_reg <= GPIO_COMBINE_RESET;
    end else begin
      for (int c = 0; c < NUM_CHANNELS; c++) begin
        channel_event_code_reg[c] <= channel_event_code_next[c];
      end
      gpio_combine_reg <= gpio_combine_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Event vector indexed by selector code
  // ---------------------------------------------------------------------------
  // Every code not listed below stays zero, so a reserved code never fires.
  always_comb begin
    gpio_combined_event = gpio_pin_event_i[0]
                        | (|gpio_pin_event_i[3:1])
                        | (|gpio_pin_event_i[15:8])
                        | (|(gpio_pin_event_i[7:4] & gpio_combine_reg));
    event_vector = '0;
    event_vector[CODE_HOST_PORT]   = host_port_event_i;
    event_vector[CODE_TIMER0]      = timer0_event_i;
    event_vector[CODE_TIMER1]      = timer1_event_i;
    event_vector[CODE_MEM_REFRESH] = memory_refresh_event_i;
    for (int k = 0; k < GPIO_SHARED_COUNT; k++) begin
      event_vector[CODE_GPIO_PIN4 + k] =
        gpio_pin_event_i[GPIO_SHARED_FIRST + k] & ~gpio_combine_reg[k];
    end
    event_vector[CODE_GPIO_COMBINED]     = gpio_combined_event;
    event_vector[CODE_GPIO_COMBINED + 1] = gpio_pin_event_i[1];
    event_vector[CODE_GPIO_COMBINED + 2] = gpio_pin_event_i[2];
    event_vector[CODE_GPIO_COMBINED + 3] = gpio_pin_event_i[3];
    event_vector[CODE_SERIAL0_TX] = serial0_tx_event_i;
    event_vector[CODE_SERIAL0_RX] = serial0_rx_event_i;
    event_vector[CODE_SERIAL1_TX] = serial1_tx_event_i;
    event_vector[CODE_SERIAL1_RX] = serial1_rx_event_i;
    for (int k = 0; k < AUDIO_EVENTS; k++) begin
      event_vector[CODE_AUDIO0_FIRST + k] = audio0_event_i[k];
      event_vector[CODE_AUDIO1_FIRST + k] = audio1_event_i[k];
    end
    event_vector[CODE_TWOWIRE0_RX] = twowire0_rx_event_i;
    event_vector[CODE_TWOWIRE0_TX] = twowire0_tx_event_i;
    event_vector[CODE_TWOWIRE1_RX] = twowire1_rx_event_i;
    event_vector[CODE_TWOWIRE1_TX] = twowire1_tx_event_i;
    for (int k = 0; k < 8; k++) begin
      event_vector[CODE_GPIO_PIN8 + k] = gpio_pin_event_i[8 + k];
    end
  end

  // ---------------------------------------------------------------------------
  // Per-channel routing
  // ---------------------------------------------------------------------------
  // An event reaches a channel only through the code currently selected, so
  // the owning peripheral's own enables decide whether it ever pulses.
  for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan
    if ((c >= CHAIN_FIRST) && (c <= CHAIN_LAST)) begin : g_chain
      assign channel_hit[c] = chain_completion_code_i[c - CHAIN_FIRST];
    end else begin : g_route
      dmaes_chan_mux u_mux (
        .code_i   (channel_event_code_reg[c]),
        .events_i (event_vector),
        .hit_o    (channel_hit[c])
      );
    end
  end

  always_comb begin
    trigger_next = channel_hit;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      trigger_reg <= '0;
    end else begin
      trigger_reg <= trigger_next;
    end
  end

  always_comb begin
    channel_trigger_o = trigger_reg;
  end

endmodule : dmaes_selector

// ===== dmaes_assertions.sv
/*
  Checker for the DMA event selector: bus timing, responses, reserved bits and chain routing.
  Assumes it is bound to dmaes_selector and sees only its ports.
*/
`timescale 1ns/1ps

module dmaes_assertions
  import dmaes_pkg::*;
(
  input wire logic                    core_clk_i,
  input wire logic                    rst_i,
  input wire logic [31:0]             avs_address_i,
  input wire logic                    avs_read_i,
  input wire logic                    avs_write_i,
  input wire logic [31:0]             avs_readdata_o,
  input wire logic                    avs_waitrequest_o,
  input wire logic [1:0]              avs_response_o,
  input wire logic [NUM_CHAIN-1:0]    chain_completion_code_i,
  input wire logic [NUM_CHANNELS-1:0] channel_trigger_o
);
  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  logic req;
  logic sel_reg;
  logic mapped;
  assign req     = avs_read_i || avs_write_i;
  assign sel_reg = avs_address_i == ADDR_ROUTE_SEL_CH0_3 || avs_address_i == ADDR_ROUTE_SEL_CH4_7
                   || avs_address_i == ADDR_ROUTE_SEL_CH12_15;
  assign mapped  = sel_reg || avs_address_i == ADDR_GPIO_COMBINE
                   || avs_address_i == ADDR_TRIGGER_STATUS;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  a_wait_one_cycle: assert property (req && avs_waitrequest_o |-> ##1 !avs_waitrequest_o)
    else $error("no answer one cycle after request");
  a_ack_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  a_no_spurious: assert property (!req && avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer without request");
  a_unmapped_err: assert property (req && avs_waitrequest_o && !mapped |=>
    avs_response_o == RESP_SLAVEERROR)
    else $error("unmapped access not refused");
  a_mapped_okay: assert property (req && avs_waitrequest_o && mapped |=>
    avs_response_o == RESP_OKAY)
    else $error("mapped access refused");
  a_rsvd_read_zero: assert property (avs_read_i && avs_waitrequest_o && sel_reg |=>
    (avs_readdata_o & ~ROUTE_SEL_WRITE_MASK) == 32'h00000000)
    else $error("reserved selector bits not zero");
  a_rdata_hold: assert property (!req |=> $stable(avs_readdata_o) && $stable(avs_response_o))
    else $error("read data changed without access");
  a_chain_route: assert property (1'b1 |=>
    channel_trigger_o[11:8] == $past(chain_completion_code_i))
    else $error("chain channel not following completion code");

  c_write: cover property (avs_write_i && !avs_waitrequest_o);
  c_read: cover property (avs_read_i && !avs_waitrequest_o);
  c_trigger: cover property (|channel_trigger_o[7:0]);
endmodule : dmaes_assertions

bind dmaes_selector dmaes_assertions u_dmaes_assertions (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
  .chain_completion_code_i(chain_completion_code_i), .channel_trigger_o(channel_trigger_o)
);

// ===== dmaes_event_src.sv
/*
  Model of the peripheral event sources: pulses the one source named by a selector code.
  Assumes fire_i and code_i change just after a rising clock edge.
*/
`timescale 1ns/1ps

module dmaes_event_src
  import dmaes_pkg::*;
(
  input  wire logic                    fire_i,
  input  wire logic [5:0]              code_i,
  output logic                         host_o,
  output logic                         tmr0_o,
  output logic                         tmr1_o,
  output logic                         refr_o,
  output logic [15:0]                  gpio_o,
  output logic [3:0]                   ser_o,
  output logic [AUDIO_EVENTS-1:0]      aud0_o,
  output logic [AUDIO_EVENTS-1:0]      aud1_o,
  output logic [3:0]                   tw_o
);
  logic [63:0] ev;
  always_comb begin
    ev = 64'h0;
    if (fire_i) ev[code_i] = 1'b1;
  end
  assign {refr_o, tmr1_o, tmr0_o, host_o} = ev[3:0];
  assign gpio_o = {ev[55:48], ev[7:4], ev[11:8]};
  assign ser_o  = ev[15:12];
  assign aud0_o = ev[37:32];
  assign aud1_o = ev[43:38];
  assign tw_o   = ev[47:44];
endmodule : dmaes_event_src

// ===== tb_dmaes_selector.sv
/*
  Self-checking bench for the DMA event selector: register access, routing of every code.
  Assumes the checker is bound to the design and the event model drives its sources.
*/
`timescale 1ns/1ps

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end

module tb_dmaes_selector
  import dmaes_pkg::*;
;
  logic core_clk_i = 0, rst_i = 1, rd = 0, wr = 0, fire = 0;
  logic [31:0] adr_q = 0, wd = 0, q, wdat, rdq, exp_reg [4];
  logic [3:0]  be = 0, chain = 0, ch, tw, ser;
  logic [5:0]  fcode = 0;
  logic [1:0]  r, rsp;
  logic        wreq;
  logic [15:0] gpio, trig;
  logic        host, t0, t1, refr;
  logic [AUDIO_EVENTS-1:0] a0, a1;
  int n_fail = 0, check_count = 0, seed = 32'h234D51D7, it, i, f, b;
  logic [31:0] adr [4] = '{ADDR_ROUTE_SEL_CH0_3, ADDR_ROUTE_SEL_CH4_7, ADDR_ROUTE_SEL_CH12_15,
                           ADDR_GPIO_COMBINE};

  always #5 core_clk_i = ~core_clk_i;

  dmaes_event_src u_dmaes_event_src (.fire_i(fire), .code_i(fcode), .host_o(host), .tmr0_o(t0),
    .tmr1_o(t1), .refr_o(refr), .gpio_o(gpio), .ser_o(ser), .aud0_o(a0), .aud1_o(a1), .tw_o(tw));

  dmaes_selector u_dmaes_selector (.core_clk_i(core_clk_i), .rst_i(rst_i), .avs_address_i(adr_q),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(q), .avs_waitrequest_o(wreq), .avs_response_o(r),
    .host_port_event_i(host), .timer0_event_i(t0), .timer1_event_i(t1),
    .memory_refresh_event_i(refr), .gpio_pin_event_i(gpio), .serial0_tx_event_i(ser[0]),
    .serial0_rx_event_i(ser[1]), .serial1_tx_event_i(ser[2]), .serial1_rx_event_i(ser[3]),
    .audio0_event_i(a0), .audio1_event_i(a1), .twowire0_rx_event_i(tw[0]),
    .twowire0_tx_event_i(tw[1]), .twowire1_rx_event_i(tw[2]), .twowire1_tx_event_i(tw[3]),
    .chain_completion_code_i(chain), .channel_trigger_o(trig));

  // ---------------------------------------------------------------------------
  // Bus master, expectations and closing
  // ---------------------------------------------------------------------------
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] rq,
                     output logic [1:0] rr);
    @(posedge core_clk_i);
    adr_q <= a;
    wd    <= d;
    wr    <= w;
    rd    <= !w;
    // Waitrequest and read data are read before this edge's register update.
    do begin
      @(posedge core_clk_i);
    end while (wreq !== 1'b0);
    rq = q;
    rr = r;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  function automatic logic [15:0] exp_trig(input int f, input logic [3:0] ch);
    logic [15:0] t;
    int c, s, p;
    t = {4'h0, ch, 8'h00};
    p = (f >= 4 && f < 8) ? f : (f >= 8 && f < 12) ? f - 8 : (f >= 48 && f < 56) ? f - 40 : -1;
    for (c = 0; c < 16; c++) if (c < 8 || c > 11) begin
      s = exp_reg[c / 4 - (c > 11)][8 * (c % 4) +: 6];
      if (s == 8) t[c] = p >= 0 && (p < 4 || p > 7 || exp_reg[3][p - 4]);
      else if (s >= 4 && s < 8) t[c] = p == s && !exp_reg[3][s - 4];
      else if (s > 8 && s < 12) t[c] = p == s - 8;
      else if (s >= 48 && s < 56) t[c] = p == s - 40;
      else t[c] = p < 0 && s == f && !(s >= 16 && s < 32) && s < 56;
    end
    return t;
  endfunction : exp_trig

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  initial begin
    #200000;
    n_fail++;
    summarize();
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    exp_reg = '{32'h03020100, 32'h07060504, 32'h0F0E0D0C, 32'h0};
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    bus(1'b1, 32'h01A0FF08, 32'hFFFFFFFF, rdq, rsp);
    `CHK(rsp, RESP_SLAVEERROR)
    bus(1'b0, 32'h01A0FF08, 32'h0, rdq, rsp);
    `CHK(rdq, 32'h0)
    `CHK(rsp, RESP_SLAVEERROR)
    for (it = 0; it < 30; it++) begin
      if (it == 15) begin
        @(posedge core_clk_i) rst_i <= 1'b1;
        @(posedge core_clk_i) rst_i <= 1'b0;
        exp_reg = '{32'h03020100, 32'h07060504, 32'h0F0E0D0C, 32'h0};
      end
      for (i = 0; i < 4; i++) begin
        bus(1'b0, adr[i], 32'h0, rdq, rsp);
        `CHK(rdq, exp_reg[i])
        `CHK(rsp, RESP_OKAY)
      end
      for (i = 0; i < 4; i++) begin
        wdat = $random(seed);
        be <= 4'($random(seed));
        bus(1'b1, adr[i], wdat, rdq, rsp);
        for (b = 0; b < 4; b++) if (be[b]) exp_reg[i][8 * b +: 8] = wdat[8 * b +: 8]
          & (i < 3 ? ROUTE_SEL_WRITE_MASK[8 * b +: 8] : (b == 0 ? 8'h0F : 8'h00));
        `CHK(rsp, RESP_OKAY)
      end
      for (f = 0; f < 64; f++) begin
        ch = 4'($random(seed));
        @(posedge core_clk_i);
        fire  <= 1'b1;
        fcode <= 6'(f);
        chain <= ch;
        @(posedge core_clk_i);
        fire  <= 1'b0;
        chain <= 4'h0;
        #1 `CHK(trig, exp_trig(f, ch))
      end
      // A steady chain code must show up in the trigger status word.
      chain <= 4'hF;
      bus(1'b0, ADDR_TRIGGER_STATUS, 32'h0, rdq, rsp);
      chain <= 4'h0;
      `CHK(rdq, 32'h00000F00)
      `CHK(rsp, RESP_OKAY)
    end
    summarize();
  end
endmodule : tb_dmaes_selector
